// ### core/nco_pkg.sv
// package: register map, field layout and reset values of the oscillator output stage
package nco_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CONTROL = 4'h0; // osc_control_reg
  localparam logic [3:0] OFS_CLOCK = 4'h4; // osc_clock_reg
  localparam logic [3:0] OFS_INCREMENT = 4'h8;
  localparam logic [3:0] OFS_ACCUM = 4'hC;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h10; // irq_request_reg
  localparam logic [4:0] OFS_IRQ_CLEAR = 5'h14;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h18; // irq_enable_reg
  localparam logic [4:0] OFS_IRQ_GLOBAL = 5'h1C;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int ACC_W = 20;
  localparam int INC_W = 16;
  localparam int PWS_W = 3;
  localparam int BIT_ENABLE = 7; // module_enable_bit
  localparam int BIT_LEVEL = 5; // output_level, read only
  localparam int BIT_POLARITY = 4; // output_polarity
  localparam int BIT_PFM = 0; // pulse_mode_select
  localparam int BIT_OVF = 0; // overflow_flag / overflow_irq_enable
  localparam int BIT_PERIPH = 6; // peripheral_irq_enable
  localparam int BIT_GLOBAL = 7; // global_irq_enable
  localparam int PWS_LSB = 5; // pulse_width_select in osc_clock_reg
  localparam int CLKSEL_LSB = 0; // clock source select field
  localparam int CLKSEL_W = 2;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [CLKSEL_W-1:0] SRC_FAST_OSC = 2'h0; // fast_internal_osc
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // pulse state, gray along idle -> active -> idle
  typedef enum logic [0:0] {
    PULSE_IDLE = 1'b0,
    PULSE_ACTIVE = 1'b1
  } pulse_state_t;

endpackage : nco_pkg

// ### core/nco_accum.sv
// phase accumulator stepped by the selected source clock enable
`timescale 1ns/1ps
module nco_accum
  import nco_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic src_tick,
  input wire logic [INC_W-1:0] increment,
  // results
  output logic [ACC_W-1:0] accum,
  output logic overflow
);

  // add with carry out of the top bit
  logic [ACC_W:0] sum;
  assign sum = {1'b0, accum} + {{(ACC_W-INC_W+1){1'b0}}, increment};

  // ----------------------------------------------------------------
  // accumulator and overflow pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      accum <= '0;
      overflow <= 1'b0;
    end else if (run && src_tick) begin
      accum <= sum[ACC_W-1:0];
      overflow <= sum[ACC_W];
    end else begin
      overflow <= 1'b0;
    end
  end

endmodule : nco_accum

// ### core/nco_pulse.sv
// output shaper: toggle or pulse of programmable width
`timescale 1ns/1ps
module nco_pulse
  import nco_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic src_tick,
  input wire logic overflow,
  input wire logic pulse_mode_select,
  input wire logic [PWS_W-1:0] pulse_width_select,
  // raw output before polarity
  output logic raw_active
);

  pulse_state_t state;
  logic [7:0] width_left;

  // width in source periods: 2^pws
  function automatic logic [7:0] pulse_periods(input logic [PWS_W-1:0] pws);
    pulse_periods = 8'h01 << pws;
  endfunction : pulse_periods

  // ----------------------------------------------------------------
  // mode logic
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      state <= PULSE_IDLE;
      raw_active <= 1'b0;
      width_left <= 8'h00;
    end else if (!pulse_mode_select) begin
      state <= PULSE_IDLE;
      width_left <= 8'h00;
      if (overflow) begin
        raw_active <= ~raw_active;
      end
    end else begin
      case (state)
        PULSE_IDLE: begin
          raw_active <= 1'b0;
          if (overflow) begin
            state <= PULSE_ACTIVE;
            raw_active <= 1'b1;
            width_left <= pulse_periods(pulse_width_select);
          end
        end
        PULSE_ACTIVE: begin
          if (src_tick) begin
            if (width_left <= 8'h01) begin
              state <= PULSE_IDLE;
              raw_active <= 1'b0;
            end else begin
              width_left <= width_left - 8'h01;
            end
          end
        end
        default: begin
          state <= PULSE_IDLE;
        end
      endcase
    end
  end

endmodule : nco_pulse

// ### core/nco_output_stage.sv
// top: register slave, clock source ticks, polarity and overflow interrupt
`timescale 1ns/1ps

module nco_output_stage
  import nco_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // source clock enables, one-cycle pulses
  input wire logic [3:0] src_tick_in,
  input wire logic sleep_mode,
  // outputs
  output logic nco_out,
  output logic to_configurable_logic_cell,
  output logic to_complementary_waveform_gen,
  output logic fast_osc_keep_on,
  output logic irq
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic module_enable_bit;
  logic output_polarity;
  logic pulse_mode_select;
  logic [PWS_W-1:0] pulse_width_select;
  logic [CLKSEL_W-1:0] clock_source;
  logic [INC_W-1:0] increment;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic peripheral_irq_enable;
  logic global_irq_enable;
  logic output_level;

  logic [ACC_W-1:0] accum;
  logic overflow;
  logic raw_active;
  logic src_tick;
  logic final_level;
  logic access_done;
  logic wr_hit;
  logic clear_hit;
  logic last_polarity;
  logic pol_changed;
  logic pol_event;

  // selected source clock enable, independent of system run state
  assign src_tick = src_tick_in[clock_source];

  // bus strobes, one cycle wait then acknowledge
  assign wr_hit = write && !waitrequest;
  assign clear_hit = wr_hit && (address == OFS_IRQ_CLEAR) && byteenable[0] && writedata[BIT_OVF];

  // ----------------------------------------------------------------
  // datapath instances
  // ----------------------------------------------------------------
  nco_accum u_accum (
    .clock(clock),
    .rst(rst),
    .run(module_enable_bit),
    .src_tick(src_tick),
    .increment(increment),
    .accum(accum),
    .overflow(overflow)
  );

  nco_pulse u_pulse (
    .clock(clock),
    .rst(rst),
    .run(module_enable_bit),
    .src_tick(src_tick),
    .overflow(overflow),
    .pulse_mode_select(pulse_mode_select),
    .pulse_width_select(pulse_width_select),
    .raw_active(raw_active)
  );

  // polarity is the last stage
  assign final_level = raw_active ^ output_polarity;

  // ----------------------------------------------------------------
  // wait state: request is answered one cycle after it rises
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  assign access_done = !waitrequest;

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      module_enable_bit <= 1'b0;
      output_polarity <= 1'b0;
      pulse_mode_select <= 1'b0;
      pulse_width_select <= '0;
      clock_source <= '0;
      increment <= '0;
      overflow_irq_enable <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
    end else if (wr_hit && byteenable[0]) begin
      if (address == OFS_CONTROL) begin
        // level bit is not written
        module_enable_bit <= writedata[BIT_ENABLE];
        output_polarity <= writedata[BIT_POLARITY];
        pulse_mode_select <= writedata[BIT_PFM];
      end else if (address == OFS_CLOCK) begin
        pulse_width_select <= writedata[PWS_LSB +: PWS_W];
        clock_source <= writedata[CLKSEL_LSB +: CLKSEL_W];
      end else if (address == OFS_INCREMENT) begin
        increment[7:0] <= writedata[7:0];
        if (byteenable[1]) begin
          increment[15:8] <= writedata[15:8];
        end
      end else if (address == OFS_IRQ_ENABLE) begin
        overflow_irq_enable <= writedata[BIT_OVF];
      end else if (address == OFS_IRQ_GLOBAL) begin
        peripheral_irq_enable <= writedata[BIT_PERIPH];
        global_irq_enable <= writedata[BIT_GLOBAL];
      end
    end else if (wr_hit && byteenable[1] && address == OFS_INCREMENT) begin
      increment[15:8] <= writedata[15:8];
    end
  end

  // ----------------------------------------------------------------
  // overflow flag: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else if (overflow) begin
      overflow_flag <= 1'b1;
    end else if (pol_event) begin
      overflow_flag <= 1'b1;
    end else if (clear_hit) begin
      overflow_flag <= 1'b0;
    end
  end

  // polarity change marker, seen in the cycle after a control write
  always_ff @(posedge clock) begin
    if (rst) begin
      last_polarity <= 1'b0;
    end else begin
      last_polarity <= output_polarity;
    end
  end

  // a polarity change flips the final output unless raw_active toggles in the same cycle: a transition event
  assign pol_changed = output_polarity != last_polarity;
  assign pol_event = pol_changed && overflow_irq_enable && module_enable_bit;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      output_level <= 1'b0;
      nco_out <= 1'b0;
      to_configurable_logic_cell <= 1'b0;
      to_complementary_waveform_gen <= 1'b0;
      fast_osc_keep_on <= 1'b0;
      irq <= 1'b0;
    end else begin
      output_level <= final_level;
      nco_out <= final_level;
      to_configurable_logic_cell <= final_level;
      to_complementary_waveform_gen <= final_level;
      fast_osc_keep_on <= module_enable_bit && (clock_source == SRC_FAST_OSC) && sleep_mode;
      irq <= overflow_flag && module_enable_bit && overflow_irq_enable
             && peripheral_irq_enable && global_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= RESET_WORD;
    end else if (read && !access_done) begin
      readdata <= UNMAPPED_READ;
      if (address == OFS_CONTROL) begin
        readdata[BIT_ENABLE] <= module_enable_bit;
        readdata[BIT_LEVEL] <= output_level;
        readdata[BIT_POLARITY] <= output_polarity;
        readdata[BIT_PFM] <= pulse_mode_select;
      end else if (address == OFS_CLOCK) begin
        readdata[PWS_LSB +: PWS_W] <= pulse_width_select;
        readdata[CLKSEL_LSB +: CLKSEL_W] <= clock_source;
      end else if (address == OFS_INCREMENT) begin
        readdata[INC_W-1:0] <= increment;
      end else if (address == OFS_ACCUM) begin
        readdata[ACC_W-1:0] <= accum;
      end else if (address == OFS_IRQ_STATUS) begin
        readdata[BIT_OVF] <= overflow_flag;
      end else if (address == OFS_IRQ_ENABLE) begin
        readdata[BIT_OVF] <= overflow_irq_enable;
      end else if (address == OFS_IRQ_GLOBAL) begin
        readdata[BIT_PERIPH] <= peripheral_irq_enable;
        readdata[BIT_GLOBAL] <= global_irq_enable;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_flag_set;
    @(posedge clock) disable iff (rst) overflow |=> overflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow did not set flag");

  property p_flag_hold;
    @(posedge clock) disable iff (rst) overflow_flag && !clear_hit |=> overflow_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

  property p_irq_gate;
    @(posedge clock) disable iff (rst) irq |-> $past(overflow_flag && module_enable_bit && overflow_irq_enable
      && peripheral_irq_enable && global_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without all enables");

  property p_toggle;
    @(posedge clock) disable iff (rst)
      overflow && module_enable_bit && !pulse_mode_select && $stable(output_polarity) |=> raw_active != $past(raw_active);
  endproperty
  a_toggle: assert property (p_toggle) else $error("fixed duty did not toggle");

  property p_pulse_start;
    @(posedge clock) disable iff (rst)
      overflow && module_enable_bit && pulse_mode_select && $stable(pulse_mode_select) |=> raw_active;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse not active after overflow");

  property p_polarity;
    @(posedge clock) disable iff (rst) nco_out == $past(raw_active ^ output_polarity);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not applied");

  property p_level_read;
    @(posedge clock) disable iff (rst) output_level == nco_out && nco_out == to_configurable_logic_cell;
  endproperty
  a_level_read: assert property (p_level_read) else $error("output copies differ");

  property p_write_ack;
    @(posedge clock) disable iff (rst) (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("no acknowledge after one wait");

  property p_pol_irq;
    @(posedge clock) disable iff (rst) pol_event |=> overflow_flag;
  endproperty
  a_pol_irq: assert property (p_pol_irq) else $error("polarity change did not raise flag");

  property p_flag_clear;
    @(posedge clock) disable iff (rst) clear_hit && !overflow && !pol_event |=> !overflow_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by software");

  property p_reset_clear;
    @(posedge clock) rst |=> !overflow_flag && !irq && !nco_out && !module_enable_bit
      && accum == '0 && increment == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");

  property p_keep_on;
    @(posedge clock) disable iff (rst)
      module_enable_bit && clock_source == SRC_FAST_OSC && sleep_mode |=> fast_osc_keep_on;
  endproperty
  a_keep_on: assert property (p_keep_on) else $error("fast oscillator not held in sleep");

  property p_keep_off;
    @(posedge clock) disable iff (rst) !sleep_mode |=> !fast_osc_keep_on;
  endproperty
  a_keep_off: assert property (p_keep_off) else $error("fast oscillator held while awake");

  property p_accum_step;
    @(posedge clock) disable iff (rst)
      module_enable_bit && src_tick |=> accum == $past(accum) + $past(increment)
      && overflow == (accum < $past(accum));
  endproperty
  a_accum_step: assert property (p_accum_step) else $error("accumulator step or carry wrong");

  property p_no_ovf;
    @(posedge clock) disable iff (rst) !(module_enable_bit && src_tick) |=> !overflow;
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("overflow without a source tick");

  property p_fixed_hold;
    @(posedge clock) disable iff (rst) module_enable_bit && !pulse_mode_select && !overflow |=> $stable(raw_active);
  endproperty
  a_fixed_hold: assert property (p_fixed_hold) else $error("fixed duty changed without overflow");

  property p_pulse_idle;
    @(posedge clock) disable iff (rst)
      module_enable_bit && pulse_mode_select && !overflow && !raw_active |=> !raw_active;
  endproperty
  a_pulse_idle: assert property (p_pulse_idle) else $error("pulse rose without overflow");

  property p_pulse_hold;
    @(posedge clock) disable iff (rst)
      module_enable_bit && pulse_mode_select && $past(pulse_mode_select) && raw_active && !src_tick |=> raw_active;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("pulse ended between source ticks");

endmodule : nco_output_stage

// ### tb/nco_far_side.sv
// far side model: logic cell and waveform generator inputs fed by the oscillator
`timescale 1ns/1ps
module nco_far_side (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // oscillator output taps
  input wire logic cell_in,
  input wire logic wave_in,
  // observations
  output int rises,
  output int mismatch
);
  logic prev;

  // count rising edges seen by the logic cell and check both taps agree
  always_ff @(posedge clock) begin
    if (rst) begin
      prev <= 1'b0;
      rises <= 0;
      mismatch <= 0;
    end else begin
      prev <= cell_in;
      if (cell_in && !prev) begin
        rises <= rises + 1;
      end
      if (cell_in !== wave_in) begin
        mismatch <= mismatch + 1;
      end
    end
  end
endmodule : nco_far_side

// ### tb/test_nco_output_stage.sv
// self-checking bench for the oscillator output stage
`timescale 1ns/1ps
module test_nco_output_stage;
  import nco_pkg::*;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0] src_tick_in = 4'h0;
  logic sleep_mode = 1'b0;
  logic nco_out, cell_tap, wave_tap, fast_osc_keep_on, irq;
  logic [31:0] q;
  logic mon_en = 1'b0;
  logic prev_out;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 59;
  int acc_m, inc_m, ovf_m, rises, run, max_run, far_rises, far_bad;
  logic [4:0] offs [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h18, 5'h1C, 5'h1E};

  // 40 MHz clock
  always #12.5 clock = ~clock;

  nco_output_stage nco_output_stage_i (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .src_tick_in(src_tick_in), .sleep_mode(sleep_mode),
    .nco_out(nco_out), .to_configurable_logic_cell(cell_tap),
    .to_complementary_waveform_gen(wave_tap), .fast_osc_keep_on(fast_osc_keep_on), .irq(irq)
  );

  nco_far_side nco_far_side_i (
    .clock(clock), .rst(rst), .cell_in(cell_tap), .wave_in(wave_tap),
    .rises(far_rises), .mismatch(far_bad)
  );

  // pulse monitor: rising edges and longest active run while ticking
  always @(posedge clock) begin
    if (rst) begin
      prev_out <= 1'b0;
      rises <= 0;
      run <= 0;
      max_run <= 0;
    end else if (mon_en) begin
      prev_out <= nco_out;
      if (nco_out && !prev_out) begin
        rises <= rises + 1;
      end
      run <= nco_out ? run + 1 : 0;
      if (nco_out && run + 1 > max_run) begin
        max_run <= run + 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    if (k >= 50) begin
      miscompares++;
      test_done();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic settle();
    repeat (4) @(posedge clock);
  endtask : settle

  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    acc_m = 0;
    ovf_m = 0;
    @(posedge clock);
  endtask : do_reset

  // model the accumulator, then drive n ticks on source s
  task automatic ticks(input logic [1:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      acc_m = acc_m + inc_m;
      if (acc_m >= (1 << ACC_W)) begin
        acc_m = acc_m - (1 << ACC_W);
        ovf_m++;
      end
    end
    src_tick_in <= 4'h1 << s;
    mon_en <= 1'b1;
    repeat (n) @(posedge clock);
    src_tick_in <= 4'h0;
    mon_en <= 1'b0;
  endtask : ticks

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    // reset values, unmapped place reads zero
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0000_0000);
      check(q, 32'h0000_0000);
    end
    // fixed duty run with a random increment, asleep meanwhile
    inc_m = int'(16'($random(seed)) | 16'h0001);
    bus(1'b1, {1'b0, OFS_INCREMENT}, 32'(inc_m));
    bus(1'b1, {1'b0, OFS_CLOCK}, 32'h0000_0000);
    bus(1'b1, {1'b0, OFS_CONTROL}, 32'h0000_00A0);
    bus(1'b0, {1'b0, OFS_CONTROL}, 32'h0000_0000);
    check(q, 32'h0000_0080);
    sleep_mode <= 1'b1;
    ticks(2'h0, 200);
    settle();
    check(32'(fast_osc_keep_on), 32'h0000_0001);
    bus(1'b0, {1'b0, OFS_ACCUM}, 32'h0000_0000);
    check(q, 32'(acc_m));
    bus(1'b0, {1'b0, OFS_CONTROL}, 32'h0000_0000);
    check(q, 32'h0000_0080 | 32'((ovf_m % 2) << 5));
    check(32'(nco_out), 32'(ovf_m % 2));
    check(32'(far_rises), 32'((ovf_m + 1) / 2));
    bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    check(q, 32'(ovf_m > 0));
    // interrupt gating and clearing
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0001);
    bus(1'b1, OFS_IRQ_GLOBAL, 32'h0000_00C0);
    settle();
    check(32'(irq), 32'(ovf_m > 0));
    bus(1'b1, OFS_IRQ_GLOBAL, 32'h0000_0040);
    settle();
    check(32'(irq), 32'h0000_0000);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h0000_0001);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    check(q, 32'h0000_0000);
    // polarity flip with interrupts on
    bus(1'b1, OFS_IRQ_GLOBAL, 32'h0000_00C0);
    bus(1'b1, {1'b0, OFS_CONTROL}, 32'h0000_0090);
    settle();
    check(32'(nco_out), 32'(1 - ovf_m % 2));
    check(32'(cell_tap), 32'(1 - ovf_m % 2));
    bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    check(q, 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    // another source keeps counting, fast osc released
    bus(1'b1, {1'b0, OFS_CLOCK}, 32'h0000_0001);
    ticks(2'h1, 30);
    settle();
    check(32'(fast_osc_keep_on), 32'h0000_0000);
    bus(1'b0, {1'b0, OFS_ACCUM}, 32'h0000_0000);
    check(q, 32'(acc_m));
    sleep_mode <= 1'b0;
    // pulse mode, every width; interval 256 ticks exceeds any width
    for (int w = 0; w < 8; w++) begin
      do_reset();
      inc_m = 4096;
      bus(1'b1, {1'b0, OFS_INCREMENT}, 32'(inc_m));
      bus(1'b1, {1'b0, OFS_CLOCK}, 32'(w << PWS_LSB));
      bus(1'b1, {1'b0, OFS_CONTROL}, 32'h0000_0081);
      ticks(2'h0, 300);
      @(posedge clock);
      ticks(2'h0, 300);
      check(32'(rises), 32'(ovf_m));
      check(32'(max_run), 32'(1 << w));
    end
    check(32'(far_bad), 32'h0000_0000);
    test_done();
  end
endmodule : test_nco_output_stage
